//--- rtl/fpcmd_pkg.sv
package fpcmd_pkg;

   // ------------------------------------------------------------
   // handshake phase codes on the mode pins (values arbitrary)
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_CMD = 4'h0;
   localparam logic [3:0] MODE_ADDR_LO = 4'h1;
   localparam logic [3:0] MODE_ADDR_HI = 4'h2;
   localparam logic [3:0] MODE_DATA = 4'h3;

   // ------------------------------------------------------------
   // command codes carried in the command phase (values arbitrary)
   // ------------------------------------------------------------
   localparam logic [15:0] CMD_SET_FLAGS = 16'h000b;
   localparam logic [15:0] CMD_CLR_FLAGS = 16'h000c;
   localparam logic [15:0] CMD_GET_FLAGS = 16'h000d;
   localparam logic [15:0] CMD_ERASE_ALL = 16'h0008;
   localparam logic [15:0] CMD_SET_SECURITY = 16'h000f;
   localparam logic [15:0] CMD_SELECT_CTRL = 16'h0034;
   localparam logic [15:0] CMD_MEM_WRITE = 16'h001f;
   localparam logic [15:0] CMD_GET_VERSION = 16'h001e;

   // ------------------------------------------------------------
   // apb register map
   // ------------------------------------------------------------
   localparam logic [11:0] REG_STATUS = 12'h000;
   localparam logic [11:0] REG_VERSION = 12'h004;
   localparam logic [11:0] REG_CTRL = 12'h008;
   localparam logic [15:0] VERSION_RST = 16'h0001;
   localparam logic CTRL_PORT_EN_RST = 1'b1;
   localparam int CTRL_PORT_EN_BIT = 0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned ERASE_HOLD_MS = 220;
   localparam int unsigned ERASE_HOLD_CYC = ERASE_HOLD_MS * (CLK_HZ / 1000);
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD_OE,
      ST_RD_REL,
      ST_WAIT_STROBE
   } fpcmd_state_t;

   typedef enum logic [1:0] {
      DEC_STATUS,
      DEC_VERSION,
      DEC_CTRL,
      DEC_NONE
   } fpcmd_dec_t;

endpackage

//--- rtl/fpcmd_sync.sv
module fpcmd_sync
   import fpcmd_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= RST;
         q_r <= RST;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;

endmodule

//--- rtl/fpcmd_core.sv
// Contract
// - set-flags command activates every flag whose mask bit is 1, bit 0 first; the code sets all of them in the same cycle.
// - clear-flags command deactivates flags whose pattern bit is 1, others kept.
// - erase-all clears every general flag as well.
// - set or clear flags uses a command write then a data write.
// - get-flags is a command write then a read returning the flag mask.
// - once secure, the port is dead and no command runs.
// - set-security is a command write then a data write of zero.
// - security clears only by erase input, after the flash erase completes; the code also clears it on presetn.
// - flash commands act on the selected controller, zero by default.
// - select-controller data 0 picks controller zero, 1 picks controller one.
// - memory-write is command, low address, high address, then data writes.
// - address advances after each data write; new address pair restarts.
// - get-version answers its data handshake with the interface version.
// - in serial mode flash data goes through jtag, not the parallel port.
// - serial mode pulls up spare pins and bypasses the crystal oscillator.
// - run from rc oscillator unless a main clock is present.
// - device latches on strobe low, drops ready, raises it after strobe high.
// - a new command phase completes the previous one and flushes the buffer.
//
// The address map and the APB interface to the registers are this design's own decisions.
module fpcmd_core
   import fpcmd_pkg::*;
#(
   parameter int FLAG_W = 3,
   parameter int unsigned ERASE_HOLD_CYCLES = ERASE_HOLD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic command_strobe_n,
   input wire logic output_enable_n,
   input wire logic [3:0] mode,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   output logic ready,
   output logic valid_n,
   input wire logic test_select,
   input wire logic prog_enable_zero,
   input wire logic prog_enable_one,
   input wire logic erase_in,
   input wire logic main_clock_active,
   output logic use_main_clock,
   output logic serial_mode,
   output logic gpio_pullup_en,
   output logic osc_bypass,
   output logic flash_ctrl_one,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic load_flush,
   output logic erase_all,
   output logic flash_erase_req,
   input wire logic flash_erase_done
);

   initial begin
      if (FLAG_W < 1 || FLAG_W > 16) $error("FLAG_W must be 1..16");
      if (ERASE_HOLD_CYCLES < 1) $error("ERASE_HOLD_CYCLES must be at least 1");
   end

   typedef struct packed {
      fpcmd_state_t st;
      logic [15:0] cmd;
      logic [31:0] addr;
      logic [FLAG_W-1:0] flags;
      logic secure;
      logic ctrl_one;
      logic load_pend;
      logic clk_ext;
      logic serial;
      logic erasing;
      logic [31:0] erase_cnt;
      logic ready;
      logic valid_n;
      logic doe;
      logic [15:0] dout;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [15:0] mem_wdata;
      logic flush;
      logic erase_all;
      logic [15:0] version;
      logic port_en;
      logic [31:0] prdata;
      logic pslverr;
   } fpcmd_regs_t;

   fpcmd_regs_t r;
   fpcmd_regs_t n;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int SW = 27;
   logic [SW-1:0] pins_s;
   logic strobe_s, noe_s, tst_s, pe0_s, pe1_s, erase_s, mclk_s;
   logic [3:0] mode_s;
   logic [15:0] data_s;

   fpcmd_sync #(.W(SW), .RST({2'b11, 25'h0})) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({command_strobe_n, output_enable_n, mode, data_in, test_select,
          prog_enable_zero, prog_enable_one, erase_in, main_clock_active}),
      .q(pins_s)
   );

   assign {strobe_s, noe_s, mode_s, data_s, tst_s, pe0_s, pe1_s, erase_s, mclk_s} = pins_s;

   function automatic fpcmd_dec_t decode(input logic [11:0] a);
      unique case (a)
         REG_STATUS: decode = DEC_STATUS;
         REG_VERSION: decode = DEC_VERSION;
         REG_CTRL: decode = DEC_CTRL;
         default: decode = DEC_NONE;
      endcase
   endfunction

   function automatic logic known_cmd(input logic [15:0] c);
      known_cmd = c inside {CMD_SET_FLAGS, CMD_CLR_FLAGS, CMD_GET_FLAGS, CMD_ERASE_ALL,
                            CMD_SET_SECURITY, CMD_SELECT_CTRL, CMD_MEM_WRITE, CMD_GET_VERSION};
   endfunction

   logic take;
   assign take = r.ready && !strobe_s;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      n.mem_we = 1'b0;
      n.flush = 1'b0;
      n.erase_all = 1'b0;
      n.serial = tst_s && pe0_s && pe1_s;
      // apb: read data and error are prepared in the setup cycle
      if (psel && !penable) begin
         n.prdata = '0;
         n.pslverr = 1'b0;
         unique case (decode(paddr))
            DEC_STATUS: begin
               n.prdata = 32'({r.flags, r.st, r.serial, r.clk_ext, r.erasing, r.ctrl_one, r.secure});
               n.pslverr = pwrite;
            end
            DEC_VERSION: n.prdata = {16'h0, r.version};
            DEC_CTRL: n.prdata = {31'h0, r.port_en};
            DEC_NONE: n.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && pwrite) begin
         unique case (decode(paddr))
            DEC_VERSION: n.version = pwdata[15:0];
            DEC_CTRL: n.port_en = pwdata[CTRL_PORT_EN_BIT];
            DEC_STATUS, DEC_NONE: ;
         endcase
      end
      // erase input must be held long enough with test-select low
      if (erase_s && !tst_s) begin
         if (r.erase_cnt < 32'(ERASE_HOLD_CYCLES)) n.erase_cnt = r.erase_cnt + 32'h1;
         if (r.erase_cnt == 32'(ERASE_HOLD_CYCLES) - 32'h1) n.erasing = 1'b1;
      end else begin
         n.erase_cnt = '0;
      end
      if (r.erasing && flash_erase_done) begin
         n.secure = 1'b0;
         n.erasing = 1'b0;
      end
      unique case (r.st)
         ST_IDLE: begin
            // serial mode or security kills the parallel port
            n.ready = !r.secure && r.port_en && !r.serial && !n.serial;
            if (take) begin
               n.ready = 1'b0;
               n.st = ST_WAIT_STROBE;
               if (mclk_s) n.clk_ext = 1'b1;
               unique case (mode_s)
                  MODE_CMD: begin
                     if (known_cmd(data_s)) begin
                        n.cmd = data_s;
                        if (r.load_pend) n.flush = 1'b1;
                        n.load_pend = 1'b0;
                     end
                  end
                  MODE_ADDR_LO: if (r.cmd == CMD_MEM_WRITE) n.addr[15:0] = data_s;
                  MODE_ADDR_HI: if (r.cmd == CMD_MEM_WRITE) n.addr[31:16] = data_s;
                  MODE_DATA: begin
                     unique case (r.cmd)
                        CMD_SET_FLAGS: n.flags = r.flags | data_s[FLAG_W-1:0];
                        CMD_CLR_FLAGS: n.flags = r.flags & ~data_s[FLAG_W-1:0];
                        CMD_ERASE_ALL: begin
                           n.flags = '0;
                           n.erase_all = 1'b1;
                        end
                        CMD_SET_SECURITY: n.secure = 1'b1;
                        CMD_SELECT_CTRL: begin
                           if (data_s == 16'h0000) n.ctrl_one = 1'b0;
                           if (data_s == 16'h0001) n.ctrl_one = 1'b1;
                        end
                        CMD_MEM_WRITE: begin
                           n.mem_we = 1'b1;
                           n.mem_addr = r.addr;
                           n.mem_wdata = data_s;
                           n.addr = r.addr + 32'h1;
                           n.load_pend = 1'b1;
                        end
                        CMD_GET_FLAGS: begin
                           n.dout = 16'(r.flags);
                           n.st = ST_RD_OE;
                        end
                        CMD_GET_VERSION: begin
                           n.dout = r.version;
                           n.st = ST_RD_OE;
                        end
                        default: ;
                     endcase
                  end
                  default: ;
               endcase
            end
         end
         ST_RD_OE: begin
            if (!noe_s) begin
               n.doe = 1'b1;
               n.valid_n = 1'b0;
               n.st = ST_RD_REL;
            end
         end
         ST_RD_REL: begin
            if (noe_s) begin
               n.doe = 1'b0;
               n.valid_n = 1'b1;
               n.st = ST_WAIT_STROBE;
            end
         end
         ST_WAIT_STROBE: begin
            // ready returns through idle two cycles after strobe_s goes high
            if (strobe_s) n.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{st: ST_IDLE, version: VERSION_RST, port_en: CTRL_PORT_EN_RST,
                valid_n: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = r.prdata;
   assign pready = 1'b1;
   assign pslverr = r.pslverr;
   assign data_out = r.dout;
   assign data_oe = r.doe;
   assign ready = r.ready;
   assign valid_n = r.valid_n;
   assign use_main_clock = r.clk_ext;
   assign serial_mode = r.serial;
   assign gpio_pullup_en = r.serial;
   assign osc_bypass = r.serial;
   assign flash_ctrl_one = r.ctrl_one;
   assign mem_we = r.mem_we;
   assign mem_addr = r.mem_addr;
   assign mem_wdata = r.mem_wdata;
   assign load_flush = r.flush;
   assign erase_all = r.erase_all;
   assign flash_erase_req = r.erasing;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_take_data(logic [15:0] c);
      take && mode_s == MODE_DATA && r.cmd == c;
   endsequence

   sequence s_read_done;
      r.st == ST_RD_REL ##1 r.st == ST_WAIT_STROBE;
   endsequence

   property p_ready_drop;
      @(posedge pclk) disable iff (!presetn) take |=> !r.ready ##0 r.st != ST_IDLE;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("ready not dropped");

   property p_ready_hold;
      @(posedge pclk) disable iff (!presetn) r.st == ST_WAIT_STROBE && !strobe_s |=> !r.ready;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready rose early");

   property p_set_flags;
      @(posedge pclk) disable iff (!presetn)
         s_take_data(CMD_SET_FLAGS) |=> r.flags == ($past(r.flags) | $past(data_s[FLAG_W-1:0]));
   endproperty
   a_set_flags: assert property (p_set_flags) else $error("set flags wrong");

   property p_clr_flags;
      @(posedge pclk) disable iff (!presetn)
         s_take_data(CMD_CLR_FLAGS) |=> r.flags == ($past(r.flags) & ~$past(data_s[FLAG_W-1:0]));
   endproperty
   a_clr_flags: assert property (p_clr_flags) else $error("clear flags wrong");

   property p_erase_all;
      @(posedge pclk) disable iff (!presetn) s_take_data(CMD_ERASE_ALL) |=> r.flags == '0 && r.erase_all;
   endproperty
   a_erase_all: assert property (p_erase_all) else $error("erase-all left flags");

   property p_secure_dead;
      @(posedge pclk) disable iff (!presetn) r.secure |=> !r.ready && !r.mem_we;
   endproperty
   a_secure_dead: assert property (p_secure_dead) else $error("port alive while secure");

   property p_sec_clear;
      @(posedge pclk) disable iff (!presetn) $fell(r.secure) |-> $past(r.erasing && flash_erase_done);
   endproperty
   a_sec_clear: assert property (p_sec_clear) else $error("security cleared without erase");

   property p_select;
      @(posedge pclk) disable iff (!presetn)
         s_take_data(CMD_SELECT_CTRL) ##0 data_s == 16'h0001 |=> r.ctrl_one ##1 flash_ctrl_one;
   endproperty
   a_select: assert property (p_select) else $error("controller one not selected");

   property p_chain;
      @(posedge pclk) disable iff (!presetn)
         s_take_data(CMD_MEM_WRITE) |=> r.mem_we && r.mem_addr == $past(r.addr) && r.addr == r.mem_addr + 32'h1;
   endproperty
   a_chain: assert property (p_chain) else $error("address did not advance");

   property p_flush;
      @(posedge pclk) disable iff (!presetn)
         take && mode_s == MODE_CMD && known_cmd(data_s) && r.load_pend |=> r.flush && !r.load_pend;
   endproperty
   a_flush: assert property (p_flush) else $error("load buffer not flushed");

   property p_unknown;
      @(posedge pclk) disable iff (!presetn)
         take && mode_s == MODE_CMD && !known_cmd(data_s) |=> r.cmd == $past(r.cmd) && !r.flush;
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown command changed state");

   property p_version;
      @(posedge pclk) disable iff (!presetn)
         s_take_data(CMD_GET_VERSION) |=> r.dout == $past(r.version) ##1 r.dout == $past(r.dout);
   endproperty
   a_version: assert property (p_version) else $error("version not returned");

   property p_read_drive;
      @(posedge pclk) disable iff (!presetn) s_read_done |-> !r.doe && r.valid_n;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("data bus not released");

   property p_serial;
      @(posedge pclk) disable iff (!presetn) r.serial |-> gpio_pullup_en && osc_bypass ##1 !r.ready;
   endproperty
   a_serial: assert property (p_serial) else $error("parallel port live in serial mode");

endmodule

//--- testbench/fpcmd_prog.sv
module fpcmd_prog
   import fpcmd_pkg::*;
(
   input wire logic pclk,
   input wire logic ready,
   input wire logic valid_n,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   output logic command_strobe_n,
   output logic output_enable_n,
   output logic [3:0] mode,
   output logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      command_strobe_n = 1'b1;
      output_enable_n = 1'b1;
      mode = MODE_DATA;
      data_in = 16'h0000;
   end

   // mode and data settle for three cycles, the sync needs two
   task automatic setup(input logic [3:0] m, input logic [15:0] d);
      @(posedge pclk);
      mode <= m;
      data_in <= d;
      repeat (3) @(posedge pclk);
      command_strobe_n <= 1'b0;
      do @(posedge pclk); while (ready !== 1'b0);
      // released lines must not keep the old value
      mode <= ~m;
      data_in <= ~d;
   endtask

   task automatic release_strobe;
      @(posedge pclk);
      command_strobe_n <= 1'b1;
   endtask

   task automatic wr(input logic [3:0] m, input logic [15:0] d);
      setup(m, d);
      release_strobe();
      do @(posedge pclk); while (ready !== 1'b1);
   endtask

   task automatic rd(output logic [15:0] q, output logic oe);
      setup(MODE_DATA, 16'h0000);
      @(posedge pclk);
      output_enable_n <= 1'b0;
      do @(posedge pclk); while (valid_n !== 1'b0);
      q = data_out;
      oe = data_oe;
      output_enable_n <= 1'b1;
      do @(posedge pclk); while (valid_n !== 1'b1);
      release_strobe();
      do @(posedge pclk); while (ready !== 1'b1);
   endtask

   // strobe with no wait, for a port that has to refuse
   task automatic poke;
      @(posedge pclk);
      command_strobe_n <= 1'b0;
      repeat (6) @(posedge pclk);
      command_strobe_n <= 1'b1;
   endtask
endmodule

//--- testbench/fpcmd_core_tb.sv
module fpcmd_core_tb
   import fpcmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr, rv;
   logic strobe_n, oe_n, data_oe, ready, valid_n, test_select, pe_zero, pe_one;
   logic erase_in, main_clk_act, use_main_clock, serial_mode, pullup_en, osc_bypass;
   logic ctrl_one, mem_we, load_flush, erase_all, flash_erase_req, flash_erase_done;
   logic [3:0] mode;
   logic [15:0] data_in, data_out, mem_wdata, q;
   int errors, comparisons, flushes, erases, cyc;
   logic [31:0] we_addr[$];
   logic [15:0] we_data[$];

   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   fpcmd_core #(.FLAG_W(3), .ERASE_HOLD_CYCLES(8)) fpcmd_core_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .command_strobe_n(strobe_n),
      .output_enable_n(oe_n), .mode(mode), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .ready(ready), .valid_n(valid_n), .test_select(test_select), .prog_enable_zero(pe_zero),
      .prog_enable_one(pe_one), .erase_in(erase_in), .main_clock_active(main_clk_act),
      .use_main_clock(use_main_clock), .serial_mode(serial_mode), .gpio_pullup_en(pullup_en),
      .osc_bypass(osc_bypass), .flash_ctrl_one(ctrl_one), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .load_flush(load_flush), .erase_all(erase_all),
      .flash_erase_req(flash_erase_req), .flash_erase_done(flash_erase_done));

   fpcmd_prog fpcmd_prog_inst (
      .pclk(pclk), .ready(ready), .valid_n(valid_n), .data_out(data_out), .data_oe(data_oe),
      .command_strobe_n(strobe_n), .output_enable_n(oe_n), .mode(mode), .data_in(data_in));

   // ------------------------------------------------------------
   // clock, timeout, monitor
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
      if (mem_we === 1'b1) begin
         we_addr.push_back(mem_addr);
         we_data.push_back(mem_wdata);
      end
      if (load_flush === 1'b1) flushes++;
      if (erase_all === 1'b1) erases++;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rst;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   task automatic wait_ready;
      do @(posedge pclk); while (ready !== 1'b1);
   endtask

   task automatic getf(input logic [15:0] exp);
      fpcmd_prog_inst.wr(MODE_CMD, CMD_GET_FLAGS);
      fpcmd_prog_inst.rd(q, oe);
      chk("flags", q, exp);
      chk("data_oe", oe, 1);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_apb;
      apb(0, REG_VERSION, 0);
      chk("version_rst", rv, {16'h0000, VERSION_RST});
      apb(1, REG_STATUS, 32'h0000_ffff);
      chk("ro_err", err, 1);
      apb(0, 12'h00c, 0);
      chk("unmapped_err", err, 1);
      apb(0, REG_STATUS, 0);
      chk("ctrl_one_rst", rv[1], 0);
      apb(1, REG_VERSION, 32'h0000_1234);
      // a disabled port ignores the strobe
      apb(1, REG_CTRL, 0);
      fpcmd_prog_inst.poke();
      chk("ready_off", ready, 0);
      apb(0, REG_STATUS, 0);
      chk("refused_state", rv[6:5], 32'(ST_IDLE));
      apb(1, REG_CTRL, 1);
      wait_ready();
   endtask

   task automatic t_flags;
      chk("main_clk_rst", use_main_clock, 0);
      main_clk_act <= 1'b1;
      fpcmd_prog_inst.wr(MODE_CMD, CMD_SET_FLAGS);
      fpcmd_prog_inst.wr(MODE_DATA, 16'hfffd);
      chk("main_clk", use_main_clock, 1);
      getf(16'h0005);
      fpcmd_prog_inst.wr(MODE_CMD, CMD_CLR_FLAGS);
      fpcmd_prog_inst.wr(MODE_DATA, 16'h0001);
      getf(16'h0004);
      apb(0, REG_STATUS, 0);
      chk("status_flags", rv[9:7], 3'b100);
      // unknown code keeps get-flags current, so its data phase is a read
      fpcmd_prog_inst.wr(MODE_CMD, 16'h0077);
      fpcmd_prog_inst.rd(q, oe);
      chk("unknown_kept", q, 16'h0004);
      getf(16'h0004);
      fpcmd_prog_inst.wr(MODE_CMD, CMD_ERASE_ALL);
      fpcmd_prog_inst.wr(MODE_DATA, 16'h0000);
      chk("erase_pulses", erases, 1);
      getf(16'h0000);
   endtask

   task automatic t_sel;
      logic [15:0] v[3] = '{16'h0001, 16'h0002, 16'h0000};
      logic e[3] = '{1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         fpcmd_prog_inst.wr(MODE_CMD, CMD_SELECT_CTRL);
         fpcmd_prog_inst.wr(MODE_DATA, v[i]);
         chk("ctrl_one", ctrl_one, e[i]);
      end
   endtask

   task automatic t_mem;
      logic [31:0] ea[4] = '{32'h0012fffe, 32'h0012ffff, 32'h00130000, 32'h00000040};
      fpcmd_prog_inst.wr(MODE_CMD, CMD_MEM_WRITE);
      fpcmd_prog_inst.wr(MODE_ADDR_LO, 16'hfffe);
      fpcmd_prog_inst.wr(MODE_ADDR_HI, 16'h0012);
      for (int i = 0; i < 3; i++) fpcmd_prog_inst.wr(MODE_DATA, 16'ha000 + 16'(i));
      fpcmd_prog_inst.wr(MODE_ADDR_LO, 16'h0040);
      fpcmd_prog_inst.wr(MODE_ADDR_HI, 16'h0000);
      fpcmd_prog_inst.wr(MODE_DATA, 16'ha003);
      chk("we_count", we_addr.size(), 4);
      for (int i = 0; i < 4 && i < we_addr.size(); i++) begin
         chk("we_addr", we_addr[i], ea[i]);
         chk("we_data", we_data[i], 16'ha000 + 16'(i));
      end
      chk("no_flush", flushes, 0);
      fpcmd_prog_inst.wr(MODE_CMD, CMD_GET_VERSION);
      chk("flush", flushes, 1);
      fpcmd_prog_inst.rd(q, oe);
      chk("version", q, 16'h1234);
   endtask

   task automatic t_serial;
      test_select <= 1'b1;
      pe_zero <= 1'b1;
      pe_one <= 1'b1;
      repeat (6) @(posedge pclk);
      chk("serial", serial_mode, 1);
      chk("pullup", pullup_en, 1);
      chk("bypass", osc_bypass, 1);
      chk("serial_ready", ready, 0);
      fpcmd_prog_inst.poke();
      chk("serial_refuse", ready, 0);
      test_select <= 1'b0;
      pe_zero <= 1'b0;
      pe_one <= 1'b0;
      wait_ready();
      chk("serial_off", serial_mode, 0);
   endtask

   task automatic t_secure;
      fpcmd_prog_inst.wr(MODE_CMD, CMD_SELECT_CTRL);
      fpcmd_prog_inst.wr(MODE_DATA, 16'h0000);
      fpcmd_prog_inst.wr(MODE_CMD, CMD_SET_SECURITY);
      fpcmd_prog_inst.setup(MODE_DATA, 16'h0000);
      fpcmd_prog_inst.release_strobe();
      repeat (8) @(posedge pclk);
      chk("secure_ready", ready, 0);
      apb(0, REG_STATUS, 0);
      chk("secure", rv[0], 1);
      fpcmd_prog_inst.poke();
      chk("secure_refuse", ready, 0);
      apb(0, REG_STATUS, 0);
      chk("secure_state", rv[6:5], 32'(ST_IDLE));
      erase_in <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("erase_early", flash_erase_req, 0);
      do @(posedge pclk); while (flash_erase_req !== 1'b1);
      apb(0, REG_STATUS, 0);
      chk("secure_hold", rv[0], 1);
      flash_erase_done <= 1'b1;
      @(posedge pclk);
      flash_erase_done <= 1'b0;
      erase_in <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(0, REG_STATUS, 0);
      chk("secure_clr", rv[0], 0);
      rst();
      getf(16'h0000);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {test_select, pe_zero, pe_one, erase_in, main_clk_act, flash_erase_done} = '0;
      {errors, comparisons, flushes, erases, cyc} = '0;
      rst();
      t_apb();
      t_flags();
      t_sel();
      t_mem();
      t_serial();
      t_secure();
      tally_and_finish();
   end
endmodule
